// file: chp_host_port.sv
// host bus slave port: asynchronous memory and multiplexed bus modes
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module chp_host_port #(
    parameter int AMI_ADDR_W = 9
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [1:0] if_sel_in,
    input wire chp_pkg::chp_ami_pins_t ami_pins_in,
    input wire logic [AMI_ADDR_W:1] ami_addr_in,
    output logic [15:0] ami_data_out,
    output logic ami_data_oe_n_out,
    input wire chp_pkg::chp_mux_pins_t mux_pins_in,
    output logic [15:0] pad_out,
    output logic pad_oe_n_out,
    input wire logic irq_req_in,
    output logic host_irq_n_out,
    output chp_pkg::chp_int_req_t int_req_out,
    output logic int_valid_out,
    input wire logic [15:0] int_rdata_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);
    import chp_pkg::*;

    localparam int BA_W = AMI_ADDR_W + 1;

    // base match: bit 10+i against input i, expanded lines all zero
    function automatic logic base_hit(input logic [15:0] adr,
                                      input logic [5:0] base,
                                      input logic [5:0] xadr);
        base_hit = (adr[15:10] == base) && (xadr == XADDR_MATCH);
    endfunction

    // narrow when addr bit 0 or strobe high; narrow writes are refused,
    // and odd address with strobe high is an unaligned half word
    function automatic logic mux_illegal(input logic adr0,
                                         input logic strobe_n,
                                         input logic is_read);
        mux_illegal = (adr0 | strobe_n) & (~is_read | (adr0 & strobe_n));
    endfunction

    function automatic logic [15:0] ami_byte_addr(
        input logic [AMI_ADDR_W:1] a);
        logic [BA_W-1:0] ba;
        ba = {a, 1'b0};
        ami_byte_addr = 16'(ba);
    endfunction

    chp_ami_pins_t ami_s1, ami_s2, ami_s3;
    chp_mux_pins_t mux_s1, mux_s2, mux_s3;
    logic [AMI_ADDR_W:1] aadr_s1, aadr_s2;
    logic [1:0] sel_s1, sel_s2;
    logic [1:0] strap_cnt;
    chp_mode_t mode;
    chp_acc_t acc_state;
    logic acc_read, acc_reject;
    logic [15:0] acc_addr;
    logic [15:0] rd_word;
    logic rd_pend;
    logic err_flag, ctrl_enable;
    logic active;
    logic ce_fall, ce_rise, clk_fall, clk_rise;
    logic st_go, st_read, st_reject, acc_end;
    logic [15:0] st_addr;
    logic wr_go;
    logic [15:0] wr_data;
    logic ill_set;
    logic bus_go;
    logic [31:0] next_rdata;

    // all pins cross two flops; third stage feeds edge detection, the multiplexed-mode fields and the write data
    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            ami_s1 <= AMI_IDLE;
            ami_s2 <= AMI_IDLE;
            ami_s3 <= AMI_IDLE;
            mux_s1 <= MUX_IDLE;
            mux_s2 <= MUX_IDLE;
            mux_s3 <= MUX_IDLE;
            aadr_s1 <= '0;
            aadr_s2 <= '0;
            sel_s1 <= 2'h0;
            sel_s2 <= 2'h0;
        end
        else
        begin
            ami_s1 <= ami_pins_in;
            ami_s2 <= ami_s1;
            ami_s3 <= ami_s2;
            mux_s1 <= mux_pins_in;
            mux_s2 <= mux_s1;
            mux_s3 <= mux_s2;
            aadr_s1 <= ami_addr_in;
            aadr_s2 <= aadr_s1;
            sel_s1 <= if_sel_in;
            sel_s2 <= sel_s1;
        end
    end

    // straps caught once after release, never looked at again
    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            strap_cnt <= 2'h0;
            mode <= MODE_WAIT;
        end
        else if (mode == MODE_WAIT)
        begin
            if (strap_cnt == STRAP_CYCLES)
            begin
                case (sel_s2)
                    SEL_CODE_MUX: mode <= MODE_MUX;
                    SEL_CODE_AMI: mode <= MODE_AMI;
                    default: mode <= MODE_HALT;
                endcase
            end
            else
            begin
                strap_cnt <= strap_cnt + 2'h1;
            end
        end
    end

    assign active = ctrl_enable && (mode == MODE_AMI || mode == MODE_MUX);

    always_comb
    begin
        ce_fall = ami_s3.host_chip_select_n && !ami_s2.host_chip_select_n;
        ce_rise = !ami_s3.host_chip_select_n && ami_s2.host_chip_select_n;
        // data phase runs while the inverted bus clock is low
        clk_fall = mux_s3.host_bus_clock_n && !mux_s2.host_bus_clock_n;
        clk_rise = !mux_s3.host_bus_clock_n && mux_s2.host_bus_clock_n;
        st_go = 1'b0;
        st_read = 1'b0;
        st_reject = 1'b0;
        st_addr = ZERO_WORD;
        if (active && mode == MODE_AMI && ce_fall)
        begin
            st_go = 1'b1;
            st_read = ami_s2.read_write_dir_n;
            st_addr = ami_byte_addr(aadr_s2);
            // word only, no byte lanes so no size error
            st_reject = (st_addr >= AMI_RSV_LO) &&
                        (st_addr <= AMI_RSV_HI);
        end
        else if (active && mode == MODE_MUX && clk_fall &&
                 base_hit(mux_s3.pad, mux_s3.base_match_inputs,
                          mux_s3.expanded_addr))
        begin
            st_go = 1'b1;
            st_read = mux_s3.read_write_dir_n;
            st_addr = mux_s3.pad;
            st_reject = mux_illegal(mux_s3.pad[0],
                                    mux_s3.low_byte_strobe_n,
                                    st_read);
        end
        acc_end = (acc_state == ACC_BUSY) &&
                  ((mode == MODE_AMI && ce_rise) ||
                   (mode == MODE_MUX && clk_rise));
        wr_go = acc_end && !acc_read && !acc_reject;
        wr_data = (mode == MODE_AMI) ? ami_s3.data : mux_s3.pad;
        ill_set = st_go && st_reject;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            acc_state <= ACC_IDLE;
            acc_read <= 1'b0;
            acc_reject <= 1'b0;
            acc_addr <= ZERO_WORD;
        end
        else
        begin
            case (acc_state)
                ACC_IDLE:
                begin
                    if (st_go)
                    begin
                        acc_state <= ACC_BUSY;
                        acc_read <= st_read;
                        acc_reject <= st_reject;
                        acc_addr <= st_addr;
                    end
                end
                ACC_BUSY:
                begin
                    if (acc_end || !active)
                    begin
                        acc_state <= ACC_IDLE;
                    end
                end
                default: acc_state <= ACC_IDLE;
            endcase
        end
    end

    // one-cycle request toward the internal register file
    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            int_valid_out <= 1'b0;
            int_req_out <= '0;
        end
        else
        begin
            int_valid_out <= 1'b0;
            if (st_go && st_read && !st_reject)
            begin
                int_valid_out <= 1'b1;
                int_req_out <= '{1'b0, st_addr, ZERO_WORD};
            end
            else if (wr_go)
            begin
                int_valid_out <= 1'b1;
                int_req_out <= '{1'b1, acc_addr, wr_data};
            end
        end
    end

    // read word: zero for rejected reads, file data one cycle after ask
    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            rd_word <= ZERO_WORD;
            rd_pend <= 1'b0;
        end
        else
        begin
            rd_pend <= int_valid_out && !int_req_out.we;
            if (st_go)
            begin
                rd_word <= ZERO_WORD;
            end
            else if (rd_pend)
            begin
                rd_word <= int_rdata_in;
            end
        end
    end

    // output drivers; enables are active low
    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            ami_data_out <= ZERO_WORD;
            pad_out <= ZERO_WORD;
            ami_data_oe_n_out <= 1'b1;
            pad_oe_n_out <= 1'b1;
        end
        else
        begin
            ami_data_out <= rd_word;
            pad_out <= rd_word;
            ami_data_oe_n_out <= !(mode == MODE_AMI &&
                acc_state == ACC_BUSY && acc_read &&
                !ami_s2.output_enable_n &&
                !ami_s2.host_chip_select_n);
            pad_oe_n_out <= !(mode == MODE_MUX &&
                acc_state == ACC_BUSY && acc_read &&
                !mux_s2.host_bus_clock_n);
        end
    end

    // a halted port raises no interrupt
    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            host_irq_n_out <= 1'b1;
        end
        else
        begin
            host_irq_n_out <= !(irq_req_in && active);
        end
    end

    // avalon slave: one wait cycle, answer at the second edge
    assign bus_go = (avs_read_in || avs_write_in) && !avs_waitrequest_out;

    always_comb
    begin
        next_rdata = 32'h00000000;
        case (avs_address_in)
            REG_STATUS:
            begin
                next_rdata[STAT_MODE_LSB +: 2] = mode;
                next_rdata[STAT_BUSY_BIT] = (acc_state == ACC_BUSY);
            end
            REG_ERROR: next_rdata[ERR_ILLEGAL_BIT] = err_flag;
            REG_CONTROL: next_rdata[CTRL_ENABLE_BIT] = ctrl_enable;
            default: next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h00000000;
        end
        else
        begin
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) &&
                                     avs_waitrequest_out);
            avs_readdata_out <= next_rdata;
        end
    end

    // error flag: hardware set wins over write-one-to-clear
    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            err_flag <= 1'b0;
        end
        else if (ill_set)
        begin
            err_flag <= 1'b1;
        end
        else if (bus_go && avs_write_in && avs_address_in == REG_ERROR &&
                 avs_writedata_in[ERR_ILLEGAL_BIT])
        begin
            err_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            ctrl_enable <= CTRL_ENABLE_RESET;
        end
        else if (bus_go && avs_write_in && avs_address_in == REG_CONTROL)
        begin
            ctrl_enable <= avs_writedata_in[CTRL_ENABLE_BIT];
        end
    end

    sequence s_bad_write_end;
        acc_state == ACC_BUSY && !acc_read && acc_reject && acc_end;
    endsequence

    sequence s_good_read_start;
        st_go && st_read && !st_reject;
    endsequence

    a_irq_level: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        irq_req_in && active |=> !host_irq_n_out)
        else $error("interrupt not asserted for pending request");

    a_ami_drive_gate: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        !ami_data_oe_n_out |-> $past(!ami_s2.output_enable_n) &&
            $past(acc_read) && $past(mode == MODE_AMI))
        else $error("memory data driven outside read with oe");

    a_pad_release: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        acc_state == ACC_BUSY && !acc_read |=> pad_oe_n_out)
        else $error("shared lines driven during a write");

    a_halt_silent: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        mode == MODE_HALT |=> !int_valid_out && ami_data_oe_n_out &&
            pad_oe_n_out && host_irq_n_out && mode == MODE_HALT)
        else $error("halted port reacted to the host");

    a_bad_write_block: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        s_bad_write_end |=> !int_valid_out)
        else $error("refused write reached the register file");

    a_err_sticky: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        ill_set |=> err_flag [*2])
        else $error("illegal access flag not set or not held");

    a_reject_zero: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        st_go && st_reject |=> !int_valid_out ##1 rd_word == ZERO_WORD)
        else $error("rejected access did not read zero");

    a_read_issue: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        s_good_read_start |=> int_valid_out && !int_req_out.we &&
            int_req_out.addr == $past(st_addr) ##2 rd_word == $past(int_rdata_in))
        else $error("read request or returned word wrong");

    a_strap_fixed: assert property (@(posedge sys_clk_in)
        disable iff (!reset_n_in)
        mode != MODE_WAIT |=> $stable(mode))
        else $error("mode changed after strap capture");

endmodule // chp_host_port

// file: chp_pkg.sv
// shared constants, types and register map of the host bus slave port
package chp_pkg;

    // interface select straps, packed as {sel1, sel0}
    localparam logic [1:0] SEL_CODE_MUX = 2'h2;
    localparam logic [1:0] SEL_CODE_AMI = 2'h1;

    typedef enum logic [1:0] {
        MODE_WAIT = 2'b00,
        MODE_MUX = 2'b01,
        MODE_AMI = 2'b10,
        MODE_HALT = 2'b11
    } chp_mode_t;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_BUSY = 2'b01
    } chp_acc_t;

    // cycles after reset release before the straps are trusted
    localparam logic [1:0] STRAP_CYCLES = 2'h3;

    // avalon register byte offsets
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_ERROR = 4'h4;
    localparam logic [3:0] REG_CONTROL = 4'h8;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_BUSY_BIT = 2;
    localparam int ERR_ILLEGAL_BIT = 0;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RESET = 1'h1;

    // reserved window of the asynchronous memory mode
    localparam logic [15:0] AMI_RSV_LO = 16'h0400;
    localparam logic [15:0] AMI_RSV_HI = 16'h1fff;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [5:0] XADDR_MATCH = 6'h00;

    typedef struct packed {
        logic host_chip_select_n;
        logic read_write_dir_n;
        logic output_enable_n;
        logic [15:0] data;
    } chp_ami_pins_t;

    typedef struct packed {
        logic host_bus_clock_n;
        logic read_write_dir_n;
        logic low_byte_strobe_n;
        logic [15:0] pad;
        logic [5:0] expanded_addr;
        logic [5:0] base_match_inputs;
    } chp_mux_pins_t;

    localparam chp_ami_pins_t AMI_IDLE = '{1'h1, 1'h1, 1'h1, 16'h0000};
    localparam chp_mux_pins_t MUX_IDLE =
        '{1'h1, 1'h1, 1'h1, 16'h0000, 6'h00, 6'h00};

    // request toward the internal register file
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } chp_int_req_t;

endpackage

// file: chp_host_model.sv
// host bus master model: memory-mode and multiplexed pins
`timescale 1ns/100ps
module chp_host_model #(
    parameter int ADDR_W = 9
) (
    input wire logic clk_in,
    input wire logic [5:0] base_in,
    input wire logic [5:0] xaddr_in,
    input wire logic [15:0] ami_data_in,
    input wire logic ami_data_oe_n_in,
    input wire logic [15:0] pad_in,
    input wire logic pad_oe_n_in,
    output chp_pkg::chp_ami_pins_t ami_pins_out,
    output logic [ADDR_W:1] ami_addr_out,
    output chp_pkg::chp_mux_pins_t mux_pins_out
);
    import chp_pkg::*;
    logic cs_n = 1'h1;
    logic oe_n = 1'h1;
    logic ck_n = 1'h1;
    logic dir = 1'h1;
    logic stb_n = 1'h1;
    logic drv = 1'h0;
    logic [15:0] hval = 16'h0000;
    logic [15:0] ami_wire;
    logic [15:0] pad_wire;
    // released lines show the inverse of the last value, not a stale copy
    assign ami_wire = !ami_data_oe_n_in ? ami_data_in : drv ? hval : ~hval;
    assign pad_wire = !pad_oe_n_in ? pad_in : drv ? hval : ~hval;
    assign ami_pins_out = {cs_n, dir, oe_n, ami_wire};
    assign mux_pins_out = {ck_n, dir, stb_n, pad_wire, xaddr_in, base_in};

    task automatic ami_xfer(input logic rd, input logic [ADDR_W:1] a,
        input logic [15:0] wd, output logic [15:0] rdat);
        @(posedge clk_in);
        cs_n <= 1'h0;
        dir <= rd;
        oe_n <= !rd;
        ami_addr_out <= a;
        hval <= wd;
        drv <= !rd;
        repeat (12) @(posedge clk_in);
        rdat = ami_wire;
        cs_n <= 1'h1;
        oe_n <= 1'h1;
        drv <= 1'h0;
        repeat (4) @(posedge clk_in);
    endtask

    // bus clock stands still high outside frames; reads get a long data phase
    task automatic mux_xfer(input logic rd, input logic sn,
        input logic [15:0] a, input logic [15:0] wd, output logic [15:0] rdat);
        @(posedge clk_in);
        dir <= rd;
        stb_n <= sn;
        hval <= a;
        drv <= 1'h1;
        repeat (4) @(posedge clk_in);
        ck_n <= 1'h0;
        drv <= !rd;
        hval <= rd ? a : wd;
        repeat (rd ? 12 : 4) @(posedge clk_in);
        rdat = pad_wire;
        ck_n <= 1'h1;
        drv <= 1'h0;
        repeat (4) @(posedge clk_in);
    endtask
endmodule // chp_host_model

// file: cc_host_bus_slave_port_test.sv
// self-checking testbench of the host bus slave port
`timescale 1ns/100ps
module cc_host_bus_slave_port_test;
    import chp_pkg::*;
    localparam int W = 13;
    logic sys_clk;
    logic reset_n = 1'h0;
    logic [1:0] if_sel = 2'h0;
    logic irq_req = 1'h0;
    logic [15:0] int_rdata = 16'h0000;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [5:0] base = 6'h0b;
    logic [5:0] xaddr = 6'h00;
    chp_ami_pins_t ami_pins;
    chp_mux_pins_t mux_pins;
    chp_int_req_t int_req;
    logic [W:1] ami_addr;
    logic [15:0] ami_data;
    logic [15:0] pad;
    logic ami_oe_n;
    logic pad_oe_n;
    logic host_irq_n;
    logic int_valid;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    int error_cnt = 0;
    int checks_done = 0;
    logic [31:0] lfsr_state = 32'h0d89;
    logic [31:0] d;
    logic [15:0] v;
    chp_int_req_t exp_q[$];

    chp_host_port #(.AMI_ADDR_W(W)) u_chp_host_port (.sys_clk_in(sys_clk),
        .reset_n_in(reset_n), .if_sel_in(if_sel), .ami_pins_in(ami_pins),
        .ami_addr_in(ami_addr), .ami_data_out(ami_data),
        .ami_data_oe_n_out(ami_oe_n), .mux_pins_in(mux_pins),
        .pad_out(pad), .pad_oe_n_out(pad_oe_n), .irq_req_in(irq_req),
        .host_irq_n_out(host_irq_n), .int_req_out(int_req),
        .int_valid_out(int_valid), .int_rdata_in(int_rdata),
        .avs_address_in(avs_address), .avs_read_in(avs_read),
        .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_readdata_out(avs_readdata),
        .avs_waitrequest_out(avs_waitrequest));
    chp_host_model #(.ADDR_W(W)) u_chp_host_model (.clk_in(sys_clk),
        .base_in(base), .xaddr_in(xaddr), .ami_data_in(ami_data),
        .ami_data_oe_n_in(ami_oe_n), .pad_in(pad), .pad_oe_n_in(pad_oe_n),
        .ami_pins_out(ami_pins), .ami_addr_out(ami_addr),
        .mux_pins_out(mux_pins));

    initial
    begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic fail(input string msg);
        error_cnt++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask

    task automatic cmp16(input logic [15:0] g, input logic [15:0] e,
        input string msg);
        checks_done++;
        if (g !== e) fail(msg);
    endtask

    task automatic cmp_req(input chp_int_req_t g, input chp_int_req_t e);
        checks_done++;
        if (g.we !== e.we || g.addr !== e.addr || (e.we && g.wdata !== e.wdata))
            fail("internal request");
    endtask

    // internal file: answers the cycle after the pulse, else keeps toggling
    always @(posedge sys_clk)
    begin
        int_rdata <= int_valid === 1'h1 ? int_req.addr ^ 16'h3c3c : ~int_rdata;
        if (reset_n === 1'h1 && int_valid === 1'h1)
        begin
            if (exp_q.size() == 0) fail("unexpected internal access");
            else cmp_req(int_req, exp_q.pop_front());
        end
    end

    task automatic avs_rd(input logic [3:0] a, output logic [31:0] rd);
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= 1'h1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
        rd = avs_readdata;
        avs_read <= 1'h0;
    endtask

    task automatic avs_wr(input logic [3:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= 1'h1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
        avs_write <= 1'h0;
    endtask

    task automatic reg_chk(input logic [3:0] a, input logic [15:0] e);
        avs_rd(a, d);
        cmp16(d[15:0], e, "register value");
    endtask

    task automatic do_reset(input logic [1:0] sel);
        @(posedge sys_clk);
        if_sel <= sel;
        reset_n <= 1'h0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'h1;
        repeat (12) @(posedge sys_clk);
    endtask

    task automatic mux_op(input logic rd, input logic sn, input logic [15:0] a,
        input logic legal, input logic sel);
        chp_int_req_t e;
        logic [15:0] got;
        lfsr_state = lfsr_next(lfsr_state);
        e = '{we: !rd, addr: a, wdata: lfsr_state[15:0]};
        if (legal) exp_q.push_back(e);
        u_chp_host_model.mux_xfer(rd, sn, a, e.wdata, got);
        if (rd && sel) cmp16(got, legal ? a ^ 16'h3c3c : ZERO_WORD,
            "mux read word");
        cmp16({15'h0000, pad_oe_n}, 16'h0001, "pad released");
    endtask

    task automatic ami_op(input logic rd, input logic [W:1] a,
        input logic legal, input logic sel);
        chp_int_req_t e;
        logic [15:0] got;
        lfsr_state = lfsr_next(lfsr_state);
        e = '{we: !rd, addr: 16'({a, 1'b0}), wdata: lfsr_state[15:0]};
        if (legal) exp_q.push_back(e);
        u_chp_host_model.ami_xfer(rd, a, e.wdata, got);
        if (rd && sel) cmp16(got, legal ? e.addr ^ 16'h3c3c : ZERO_WORD,
            "memory read word");
        cmp16({15'h0000, ami_oe_n}, 16'h0001, "data released");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail("watchdog expired");
        summarize();
    end

    initial
    begin
        do_reset(SEL_CODE_MUX);
        reg_chk(REG_STATUS, 16'h0001);
        reg_chk(REG_CONTROL, 16'h0001);
        reg_chk(4'hc, 16'h0000);
        mux_op(1'h1, 1'h0, {base, 10'h024}, 1'h1, 1'h1);
        mux_op(1'h0, 1'h0, {base, 10'h3fe}, 1'h1, 1'h1);
        mux_op(1'h1, 1'h0, {base, 10'h013}, 1'h1, 1'h1);
        mux_op(1'h1, 1'h0, {6'h34, 10'h024}, 1'h0, 1'h0);
        xaddr <= 6'h01;
        mux_op(1'h1, 1'h0, {base, 10'h024}, 1'h0, 1'h0);
        xaddr <= 6'h00;
        reg_chk(REG_ERROR, 16'h0000);
        mux_op(1'h0, 1'h1, {base, 10'h040}, 1'h0, 1'h1);
        reg_chk(REG_ERROR, 16'h0001);
        avs_wr(REG_ERROR, 32'h1);
        reg_chk(REG_ERROR, 16'h0000);
        mux_op(1'h1, 1'h1, {base, 10'h041}, 1'h0, 1'h1);
        reg_chk(REG_ERROR, 16'h0001);
        avs_wr(REG_ERROR, 32'h1);
        irq_req <= 1'h1;
        repeat (4) @(posedge sys_clk);
        cmp16({15'h0000, host_irq_n}, 16'h0000, "irq asserted");
        avs_wr(REG_CONTROL, 32'h0);
        repeat (4) @(posedge sys_clk);
        cmp16({15'h0000, host_irq_n}, 16'h0001, "irq masked");
        mux_op(1'h1, 1'h0, {base, 10'h024}, 1'h0, 1'h0);
        avs_wr(REG_CONTROL, 32'h1);
        irq_req <= 1'h0;
        repeat (4) @(posedge sys_clk);
        cmp16({15'h0000, host_irq_n}, 16'h0001, "irq released");
        $display("test multiplexed mode done");
        do_reset(SEL_CODE_AMI);
        reg_chk(REG_STATUS, 16'h0002);
        for (int i = 0; i < 4; i++)
        begin
            lfsr_state = lfsr_next(lfsr_state);
            v = lfsr_state[15:0];
            ami_op(v[15], {4'h0, v[8:0]}, 1'h1, 1'h1);
        end
        ami_op(1'h1, 13'h0200, 1'h0, 1'h1);
        ami_op(1'h0, 13'h0fff, 1'h0, 1'h1);
        reg_chk(REG_ERROR, 16'h0001);
        $display("test memory mode done");
        do_reset(2'h0);
        reg_chk(REG_STATUS, 16'h0003);
        ami_op(1'h1, 13'h0010, 1'h0, 1'h0);
        cmp16(16'(exp_q.size()), 16'h0000, "requests left over");
        $display("test unsupported straps done");
        summarize();
    end
endmodule // cc_host_bus_slave_port_test
